// ===== adc_seq_map.svh
// constants for the six-channel conversion sequencer
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
`define CLKS_PER_CHAN      7'h10
`define FULL_CLKS          7'h60
`define NUM_CHAN           3'h6
`define WORD_W             16
`define NAP_PULSES         3'h2
`define SLEEP_PULSES       3'h4
`define REF_SETTLE_MS      2
`define CLK_MHZ            125
`define REF_SETTLE_CYC     (`REF_SETTLE_MS * 1000 * `CLK_MHZ)
`endif

// ===== adc_seq_pkg.sv
// types for the six-channel conversion sequencer
package adc_seq_pkg;
   typedef enum logic [1:0] {pwr_active, pwr_nap, pwr_sleep} pwr_mode_t;
   typedef struct packed {
      logic [15:0] ch0;
      logic [15:0] ch1;
      logic [15:0] ch2;
      logic [15:0] ch3;
      logic [15:0] ch4;
      logic [15:0] ch5;
   } sample_set_t;
   typedef struct packed {
      logic       sdo;
      logic       sdo_oe;
   } sdo_pin_t;
endpackage

// ===== sync2.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync2 (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic d_i,
   output var  logic q_o
);
   logic meta_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         q_o    <= 1'b0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== adc_convert_strobe_seq.sv
// conversion sequencer: link side on sck, power control on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"
//
// Contract
// [R1] sixteen link clocks per enabled channel
// [R2] acquisition from 96th edge to strobe; code only reaches it with six channels enabled
// [R3] late strobe delays output one clock
// [R4] host raises strobe half period early; late frames raise it 2 ns before sck
// [R5] link clocks wake; reference settles 2ms
// [R6] host keeps clock 40..10000 ns converting
// [R7] host samples data on rising edge
// [R8] host waits 45 ns after 96th edge
// [R9] host conversion cycle at least 4 us
// [R10] strobe rise holds inputs, starts conversion
// [R11] previous results, channel 0 first, msb first
// [R12] channel select decode, fixed during use
// [R13] two strobes nap, four strobes sleep
// [R14] data output released after last bit
module adc_convert_strobe_seq #(
   parameter int unsigned SETTLE_CYC = `REF_SETTLE_CYC
) (
   input  wire logic                       clk_i,
   input  wire logic                       sys_rst_i,
   input  wire logic                       sck_i,
   input  wire logic                       convert_strobe_i,
   input  wire logic                       late_strobe_i,
   input  wire logic                       chan_count_sel_msb_i,
   input  wire logic                       chan_count_sel_mid_i,
   input  wire logic                       chan_count_sel_lsb_i,
   input  wire logic                       bipolar_range_select_i,
   input  wire adc_seq_pkg::sample_set_t   analog_i,
   output var  adc_seq_pkg::sdo_pin_t      sdo_pin_o,
   output var  logic                       acquiring_o,
   output var  logic                       converting_o,
   output var  adc_seq_pkg::pwr_mode_t     pwr_mode_o,
   output var  logic                       ref_ready_o
);
   ////////////////////////////////////////////////////////////////////
   // link domain (sck). the strobe edge is seen at the next sck rise,
   // as the real part does; no sck while the strobe is high means no start.
   logic [2:0]              sel;
   logic [2:0]              nchan;
   logic [6:0]              total_clks;
   logic                    strobe_q;
   logic                    start_pend_q;
   logic                    start;
   logic                    convert_strobe_q;
   logic [6:0]              cnt_q;
   logic                    acq_q;
   logic                    skip_q;
   logic [95:0]             shift_q;
   logic [95:0]             result_q;
   logic [95:0]             held_q;
   logic [6:0]              out_cnt_q;
   logic                    sdo_q;
   logic                    oe_q;
   logic                    strobe_rise;
   logic [95:0]             convert_strobe_word;
   logic                    link_tog_q;

   assign sel = {chan_count_sel_msb_i, chan_count_sel_mid_i,
                 chan_count_sel_lsb_i};
   assign nchan = (sel >= 3'h5) ? `NUM_CHAN : sel + 3'h1; // R12
   assign total_clks = {4'h0, nchan} * `CLKS_PER_CHAN; // R1
   assign strobe_rise = convert_strobe_i & ~strobe_q;
   assign start = strobe_rise | start_pend_q;
   // unipolar codes flip sign bit so both ranges share one path
   assign convert_strobe_word = bipolar_range_select_i ? held_q :
                      held_q ^ {6{16'h8000}};

   always_ff @(posedge sck_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         strobe_q     <= 1'b0;
         start_pend_q <= 1'b0;
         held_q       <= '0;
      end else begin
         strobe_q     <= convert_strobe_i;
         start_pend_q <= 1'b0;
         // inputs are held at the strobe edge even when the start slips
         if (strobe_rise) begin
            held_q <= analog_i; // R10
         end
         if (strobe_rise && late_strobe_i) begin
            start_pend_q <= 1'b1; // R3
         end
      end
   end

   always_ff @(posedge sck_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         convert_strobe_q    <= 1'b0;
         cnt_q     <= 7'h00;
         acq_q     <= 1'b1;
         result_q  <= '0;
         out_cnt_q <= 7'h00;
         sdo_q     <= 1'b0;
         oe_q      <= 1'b0;
         shift_q   <= '0;
      end else if (start && !(strobe_rise && late_strobe_i)) begin
         convert_strobe_q    <= 1'b1; // R10
         acq_q     <= 1'b0; // R2
         cnt_q     <= 7'h01;
         shift_q   <= result_q; // R11
         out_cnt_q <= 7'h01;
         sdo_q     <= result_q[95];
         oe_q      <= 1'b1;
      end else begin
         if (convert_strobe_q) begin
            cnt_q <= cnt_q + 7'h01;
            if (cnt_q == `FULL_CLKS - 7'h01) begin
               acq_q <= 1'b1; // R2
            end
            if (cnt_q == total_clks - 7'h01) begin
               convert_strobe_q   <= 1'b0; // R1
               result_q <= convert_strobe_word;
            end
         end
         if (oe_q) begin
            if (out_cnt_q == total_clks) begin
               oe_q <= 1'b0; // R14
            end else begin
               shift_q   <= {shift_q[94:0], 1'b0};
               sdo_q     <= shift_q[94]; // R11
               out_cnt_q <= out_cnt_q + 7'h01;
            end
         end
      end
   end

   assign sdo_pin_o   = '{sdo: sdo_q, sdo_oe: oe_q};
   assign converting_o = convert_strobe_q;
   assign acquiring_o  = acq_q;

   always_ff @(posedge sck_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         link_tog_q <= 1'b0;
      end else begin
         link_tog_q <= ~link_tog_q; // R5
      end
   end

   ////////////////////////////////////////////////////////////////////
   // system domain: counts strobe pulses while sck stands still
   logic                    strobe_s;
   logic                    tog_s;
   logic                    strobe_s_q;
   logic                    tog_s_q;
   logic                    sck_seen;
   logic [2:0]              pulses_q;
   adc_seq_pkg::pwr_mode_t  mode_q;
   logic [31:0]             settle_q;

   sync2 u_sync_strobe (
      .clk_i (clk_i),
      .rst_i (sys_rst_i),
      .d_i   (convert_strobe_i),
      .q_o   (strobe_s)
   );
   sync2 u_sync_tog (
      .clk_i (clk_i),
      .rst_i (sys_rst_i),
      .d_i   (link_tog_q),
      .q_o   (tog_s)
   );

   assign sck_seen = tog_s ^ tog_s_q;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         strobe_s_q <= 1'b0;
         tog_s_q    <= 1'b0;
         pulses_q   <= 3'h0;
         mode_q     <= adc_seq_pkg::pwr_active;
         settle_q   <= 32'h0;
      end else begin
         strobe_s_q <= strobe_s;
         tog_s_q    <= tog_s;
         if (sck_seen) begin
            pulses_q <= 3'h0; // R5
            if (mode_q == adc_seq_pkg::pwr_sleep) begin
               settle_q <= SETTLE_CYC;
            end
            mode_q <= adc_seq_pkg::pwr_active;
         end else begin
            if (settle_q != 32'h0) begin
               settle_q <= settle_q - 32'h1; // R5
            end
            if (strobe_s & ~strobe_s_q && pulses_q != 3'h7) begin
               pulses_q <= pulses_q + 3'h1;
            end
            case (pulses_q)
               `NAP_PULSES: mode_q <= adc_seq_pkg::pwr_nap; // R13
               `SLEEP_PULSES: mode_q <= adc_seq_pkg::pwr_sleep; // R13
               default: ;
            endcase
         end
      end
   end

   assign pwr_mode_o  = mode_q;
   assign ref_ready_o = (settle_q == 32'h0);

   ////////////////////////////////////////////////////////////////////
   a_convert_strobe_len: assert property ( // R1
      @(posedge sck_i) disable iff (sys_rst_i)
      $fell(convert_strobe_q) |-> cnt_q == total_clks)
      else $error("conversion length wrong");
   a_acq_start: assert property ( // R2
      @(posedge sck_i) disable iff (sys_rst_i)
      (convert_strobe_q && cnt_q == `FULL_CLKS - 7'h01 && !start) |=> acq_q)
      else $error("acquisition did not begin");
   a_late_delay: assert property ( // R3
      @(posedge sck_i) disable iff (sys_rst_i)
      (strobe_rise && late_strobe_i && !convert_strobe_q) |=>
      !convert_strobe_q ##1 (convert_strobe_q && cnt_q == 7'h01))
      else $error("late strobe not delayed");
   a_start_convert_strobe: assert property ( // R10
      @(posedge sck_i) disable iff (sys_rst_i)
      (strobe_rise && !late_strobe_i) |=> convert_strobe_q && cnt_q == 7'h01)
      else $error("conversion did not start");
   a_msb_first: assert property ( // R11
      @(posedge sck_i) disable iff (sys_rst_i)
      (oe_q && out_cnt_q != total_clks && !start) |=>
      sdo_q == $past(shift_q[94]))
      else $error("bit order wrong");
   a_sel_decode: assert property ( // R12
      @(posedge sck_i) disable iff (sys_rst_i)
      sel[2] & (sel[1] | sel[0]) |-> nchan == `NUM_CHAN)
      else $error("channel select decode wrong");
   a_release: assert property ( // R14
      @(posedge sck_i) disable iff (sys_rst_i)
      (oe_q && out_cnt_q == total_clks && !start) |=> !oe_q)
      else $error("output not released");
   a_wake: assert property ( // R5
      @(posedge clk_i) disable iff (sys_rst_i)
      sck_seen |=> mode_q == adc_seq_pkg::pwr_active)
      else $error("no wake on link clock");
   a_sleep: assert property ( // R13
      @(posedge clk_i) disable iff (sys_rst_i)
      (pulses_q == `SLEEP_PULSES && !sck_seen) |=>
      mode_q == adc_seq_pkg::pwr_sleep)
      else $error("sleep not entered");
   c_full: cover property (@(posedge sck_i) $fell(convert_strobe_q) && nchan == 3'h6);
   c_late: cover property (@(posedge sck_i) strobe_rise && late_strobe_i);
   c_nap: cover property (@(posedge clk_i)
      mode_q == adc_seq_pkg::pwr_nap);
   c_sleep: cover property (@(posedge clk_i)
      mode_q == adc_seq_pkg::pwr_sleep);
endmodule
`default_nettype wire

// ===== adc_host.sv
// host controller model: drives link clock and convert strobe, reads data
`timescale 1ns/1ps
`default_nettype none
module adc_host (
   output logic      sck_o,
   output logic      strobe_o,
   output logic      late_o,
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i
);
   localparam int HALF = 24;
   logic [95:0] rx_q;
   logic        oe_last_q;
   initial begin
      sck_o = 1'b0;
      strobe_o = 1'b0;
      late_o = 1'b0;
      rx_q = '0;
      oe_last_q = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // link clock runs inside a frame and for one wake pulse, low otherwise
   task automatic frame(input int n, input logic late);
      rx_q = '0;
      late_o = late;
      #(late ? HALF - 2 : 0);
      strobe_o = 1'b1;
      #(late ? 2 : HALF);
      sck_o = 1'b1;
      if (late) begin
         #HALF sck_o = 1'b0;
         #HALF sck_o = 1'b1;
      end
      for (int k = 0; k < 16 * n; k++) begin
         #HALF sck_o = 1'b0;
         strobe_o = 1'b0;
         // a released line reads back as the inverse of its last bit
         #HALF rx_q = {rx_q[94:0], sdo_oe_i ? sdo_i : ~sdo_i};
         oe_last_q = sdo_oe_i;
         sck_o = 1'b1;
      end
      #HALF sck_o = 1'b0;
      late_o = 1'b0;
      // idle keeps the per-channel rate and acquisition gap legal
      #4000;
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         #HALF strobe_o = 1'b1;
         #HALF strobe_o = 1'b0;
      end
   endtask
   task automatic wake();
      #HALF sck_o = 1'b1;
      #HALF sck_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== six_channel_adc_conversion_sequencer_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module six_channel_adc_conversion_sequencer_bench;
   logic                     clk_i, sys_rst_i, bipolar_range_select;
   logic [2:0]               sel;
   adc_seq_pkg::sample_set_t analog, held, prev;
   adc_seq_pkg::sdo_pin_t    sdo_pin;
   adc_seq_pkg::pwr_mode_t   mode;
   logic                     acq, convert_strobe, ref_rdy;
   wire logic                sck, strobe, late;
   int                       fails = 0;
   int                       tests_run = 0;
   adc_convert_strobe_seq #(.SETTLE_CYC(10)) dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck),
      .convert_strobe_i(strobe), .late_strobe_i(late),
      .chan_count_sel_msb_i(sel[2]), .chan_count_sel_mid_i(sel[1]),
      .chan_count_sel_lsb_i(sel[0]), .bipolar_range_select_i(bipolar_range_select),
      .analog_i(analog), .sdo_pin_o(sdo_pin), .acquiring_o(acq),
      .converting_o(convert_strobe), .pwr_mode_o(mode), .ref_ready_o(ref_rdy));
   adc_host host (.sck_o(sck), .strobe_o(strobe), .late_o(late),
      .sdo_i(sdo_pin.sdo), .sdo_oe_i(sdo_pin.sdo_oe));
   always #4 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [95:0] seen, input logic [95:0] exp,
                        input string what);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   function automatic logic [95:0] readout(input logic [95:0] s, input int n);
      return s >> (96 - 16 * n);
   endfunction
   // unipolar results come back as offset binary
   function automatic logic [95:0] coded(input logic [95:0] s,
                                         input logic       b);
      return b ? s : s ^ {6{16'h8000}};
   endfunction
   function automatic int chans(input logic [2:0] s);
      return (s > 3'h5) ? 6 : int'(s) + 1;
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // inputs change after the strobe to prove they were held at the strobe
   task automatic run_frame(input logic cmp);
      int   n;
      logic lt;
      n = chans(sel);
      lt = 1'($urandom % 2);
      @(negedge clk_i);
      analog = {$urandom, $urandom, $urandom};
      held = analog;
      fork
         host.frame(n, lt);
         begin
            @(posedge sck);
            @(negedge clk_i);
            analog = {$urandom, $urandom, $urandom};
         end
      join
      @(negedge clk_i);
      if (cmp) check(host.rx_q, readout(prev, n), "serial data");
      check(96'(host.oe_last_q), 96'h1, "enable before last bit");
      check(96'(sdo_pin.sdo_oe), 96'h0, "enable after last bit");
      check(96'(convert_strobe), 96'h0, "conversion finished");
      if (n == 6) check(96'(acq), 96'h1, "acquisition");
      prev = coded(held, bipolar_range_select);
   endtask
   initial begin
      clk_i = 1'b0;
      sys_rst_i = 1'b1;
      bipolar_range_select = 1'b0;
      sel = 3'h0;
      analog = '0;
      void'($urandom(87241));
      repeat (6) @(posedge clk_i);
      @(negedge clk_i) sys_rst_i = 1'b0;
      check(96'(convert_strobe), 96'h0, "converting after reset");
      check(96'(acq), 96'h1, "acquiring after reset");
      check(96'(sdo_pin.sdo_oe), 96'h0, "enable after reset");
      check(96'(mode), 96'(adc_seq_pkg::pwr_active), "mode after reset");
      check(96'(ref_rdy), 96'h1, "reference after reset");
      for (int s = 0; s < 8; s++) begin
         @(negedge clk_i) sel = 3'(s);
         bipolar_range_select = s[0];
         run_frame(1'b0);
         run_frame(1'b1);
      end
      host.pulses(2);
      repeat (10) @(negedge clk_i);
      check(96'(mode), 96'(adc_seq_pkg::pwr_nap), "nap");
      host.wake();
      repeat (10) @(negedge clk_i);
      check(96'(mode), 96'(adc_seq_pkg::pwr_active), "wake nap");
      host.pulses(4);
      repeat (10) @(negedge clk_i);
      check(96'(mode), 96'(adc_seq_pkg::pwr_sleep), "sleep");
      host.wake();
      repeat (2) @(negedge clk_i);
      check(96'(ref_rdy), 96'h0, "reference settling");
      repeat (30) @(negedge clk_i);
      check(96'(ref_rdy), 96'h1, "reference ready");
      check(96'(mode), 96'(adc_seq_pkg::pwr_active), "wake sleep");
      tally_and_finish();
   end
   initial begin
      #400000;
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
